/* File: usr_bus_model.sv */
// bus logic on the far side of the shared parallel pins
module usr_bus_model (
  // clock
  input wire logic clk,
  // device side of the pins
  input wire logic [7:0] devOut,
  input wire logic [7:0] devOe,
  // bench request to drive load data
  input wire logic drvEn,
  input wire logic [7:0] drvData,
  // resolved pin level
  output logic [7:0] pinLevel
);
  logic [7:0] lastLevel;

  always_ff @(posedge clk) begin
    lastLevel <= pinLevel;
  end

  // drives only where the device floats; nobody driving means a wandering level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (devOe[i]) begin
        pinLevel[i] = devOut[i];
      end else if (drvEn) begin
        pinLevel[i] = drvData[i];
      end else begin
        pinLevel[i] = ~lastLevel[i];
      end
    end
  end
endmodule

/* File: usr_fifo.sv */
// synchronous fifo with valid/ready on both sides
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign level = wrPtr - rdPtr;
  assign inReady = (level != (AW + 1)'(DEPTH));
  assign outValid = (wrPtr != rdPtr);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
    end else if (push) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdPtr <= '0;
    end else if (pop) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule

/* File: usr_pkg.sv */
// types shared by the universal shift register block
package usr_pkg;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_SHIFT_RIGHT = 2'b01,
    MODE_SHIFT_LEFT = 2'b10,
    MODE_LOAD = 2'b11
  } usr_mode_t;

  typedef struct packed {
    logic high;
    logic low;
  } usr_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } usr_bus_req_t;

  typedef struct packed {
    logic rightIn;
    logic leftIn;
  } usr_serial_t;

  // high select with low select forms the two-bit mode code
  function automatic usr_mode_t usr_decode_mode(input usr_sel_t sel);
    case ({sel.high, sel.low})
      2'b11: usr_decode_mode = MODE_LOAD;
      2'b01: usr_decode_mode = MODE_SHIFT_RIGHT;
      2'b10: usr_decode_mode = MODE_SHIFT_LEFT;
      default: usr_decode_mode = MODE_HOLD;
    endcase
  endfunction

endpackage

/* File: usr_regs.svh */
// register offsets, fields and reset values of the universal shift register block
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

`define USR_ADDR_W 8
`define USR_DATA_W 32

`define USR_CTRL_ADDR 8'h00
`define USR_STATUS_ADDR 8'h04
`define USR_FIFO_ADDR 8'h08
`define USR_LEVEL_ADDR 8'h0c

`define USR_CTRL_CAPTURE_BIT 0
`define USR_CTRL_RESET 1'b0

`define USR_STAT_STATE_LSB 0
`define USR_STAT_DRIVE_BIT 8
`define USR_STAT_MODE_LSB 9
`define USR_STAT_EMPTY_BIT 11
`define USR_STAT_FULL_BIT 12
`define USR_STAT_PEND_BIT 13

`define USR_FIFO_VALID_BIT 8

`define USR_STATE_RESET 8'h00
`define USR_READ_ZERO 32'h0000_0000

`endif

/* File: usr_shift_core.sv */
// eight-stage storage register with shift, load and hold interstage logic
`include "usr_regs.svh"

module usr_shift_core #(
  parameter int WIDTH = 8
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_clear_n,
  // operation
  input wire logic stepEn,
  input wire usr_pkg::usr_mode_t mode,
  input wire logic [WIDTH-1:0] parallelIn,
  input wire usr_pkg::usr_serial_t serialIn,
  // stored word
  output logic [WIDTH-1:0] state
);
  // the clear needs no clock, so it sits in the sensitivity list
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      state <= '0;
    end else if (!rst_n) begin
      state <= '0;
    end else if (stepEn) begin
      case (mode)
        usr_pkg::MODE_LOAD: state <= parallelIn;
        usr_pkg::MODE_SHIFT_RIGHT: state <= {state[WIDTH-2:0], serialIn.rightIn};
        usr_pkg::MODE_SHIFT_LEFT: state <= {serialIn.leftIn, state[WIDTH-1:1]};
        default: state <= state;
      endcase
    end
  end
endmodule

/* File: usr_top.sv */
// universal shift register top: pin logic, register port, capture fifo and checks
// Notes on behaviour
// - eight D storage stages with shift right, shift left, load and hold.
// - high and low selects choose load, shift right, shift left or hold.
// - load mode captures each parallel pin into its register bit on the edge.
// - shift right puts serial right input in bit 0, bit n takes n-1.
// - shift left puts serial left input in bit 7, bit n takes n+1.
// - both selects low keeps the stored word unchanged.
// - master clear low zeroes all bits at once, over selects and clock.
// - apart from the clear and rst_n, state changes only on a rising shift clock or on its deferred replay when the capture fifo frees up.
// - enabled parallel pins drive the current register contents.
// - either drive enable high floats the parallel pins.
// - register keeps working normally while the pins float.
// - both selects high floats the pins regardless of drive enables.
// - bits 0 and 7 drive two serial outputs, unaffected by enables.
`include "usr_regs.svh"

module usr_top #(
  parameter int WIDTH = 8,
  parameter int FIFO_DEPTH = 32
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_clear_n,
  // device control pins
  input wire logic shift_clock,
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  input wire logic right_shift_serial_in,
  input wire logic left_shift_serial_in,
  input wire logic pin_drive_enable_a_n,
  input wire logic pin_drive_enable_b_n,
  // shared parallel pins, split into three signals
  input wire logic [WIDTH-1:0] sharedParallelPinsIn,
  output logic [WIDTH-1:0] sharedParallelPinsOut,
  output logic [WIDTH-1:0] sharedParallelPinsOe,
  // serial outputs for cascading
  output logic serial_out_first_bit,
  output logic serial_out_last_bit,
  // register port
  input wire logic [`USR_ADDR_W-1:0] regAddr,
  input wire logic [`USR_DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`USR_DATA_W-1:0] regRdata
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  usr_pkg::usr_bus_req_t busReq;
  usr_pkg::usr_sel_t modeSel;
  usr_pkg::usr_serial_t serialIn;
  usr_pkg::usr_mode_t mode;
  logic [WIDTH-1:0] state;
  logic captureEn;
  logic clockPrev;
  logic clockRise;
  logic pending;
  logic next_pending;
  logic wantStep;
  logic room;
  logic stepEn;
  logic pinsDriven;
  logic capValid;
  logic [WIDTH-1:0] capData;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [WIDTH-1:0] fifoOutData;
  logic [LW-1:0] fifoLevel;
  logic [`USR_DATA_W-1:0] next_rdata;

  assign busReq = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign modeSel = '{high: mode_select_high, low: mode_select_low};
  assign serialIn = '{rightIn: right_shift_serial_in, leftIn: left_shift_serial_in};
  assign mode = usr_pkg::usr_decode_mode(modeSel);

  // shift clock is a plain sampled input; its rising edge becomes a step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clockPrev <= 1'b0;
    end else begin
      clockPrev <= shift_clock;
    end
  end

  assign clockRise = shift_clock && !clockPrev;
  assign wantStep = clockRise || pending;
  // a full capture fifo defers the step rather than dropping a snapshot
  assign room = !captureEn || fifoInReady;
  assign stepEn = wantStep && room;
  assign next_pending = wantStep && !room;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  usr_shift_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .clk(clk),
    .rst_n(rst_n),
    .master_clear_n(master_clear_n),
    .stepEn(stepEn),
    .mode(mode),
    .parallelIn(sharedParallelPinsIn),
    .serialIn(serialIn),
    .state(state)
  );

  // pin drive: off when either enable is high or load mode is selected
  assign pinsDriven = !pin_drive_enable_a_n && !pin_drive_enable_b_n
    && (mode != usr_pkg::MODE_LOAD);
  assign sharedParallelPinsOe = {WIDTH{pinsDriven}};
  assign sharedParallelPinsOut = state;
  assign serial_out_first_bit = state[0];
  assign serial_out_last_bit = state[WIDTH-1];

  // snapshot of the stored word, taken the cycle after each step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capValid <= 1'b0;
    end else begin
      capValid <= stepEn && captureEn;
    end
  end

  assign capData = state;

  usr_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(capValid),
    .inReady(fifoInReady),
    .inData(capData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // reading the fifo word pops it
  assign fifoPop = busReq.rd && (busReq.addr == `USR_FIFO_ADDR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      captureEn <= `USR_CTRL_RESET;
    end else if (busReq.wr && busReq.addr == `USR_CTRL_ADDR) begin
      captureEn <= busReq.wdata[`USR_CTRL_CAPTURE_BIT];
    end
  end

  always_comb begin
    next_rdata = `USR_READ_ZERO;
    case (busReq.addr)
      `USR_CTRL_ADDR: begin
        next_rdata[`USR_CTRL_CAPTURE_BIT] = captureEn;
      end
      `USR_STATUS_ADDR: begin
        next_rdata[`USR_STAT_STATE_LSB +: WIDTH] = state;
        next_rdata[`USR_STAT_DRIVE_BIT] = pinsDriven;
        next_rdata[`USR_STAT_MODE_LSB +: 2] = mode;
        next_rdata[`USR_STAT_EMPTY_BIT] = !fifoOutValid;
        next_rdata[`USR_STAT_FULL_BIT] = !fifoInReady;
        next_rdata[`USR_STAT_PEND_BIT] = pending;
      end
      `USR_FIFO_ADDR: begin
        next_rdata[WIDTH-1:0] = fifoOutValid ? fifoOutData : '0;
        next_rdata[`USR_FIFO_VALID_BIT] = fifoOutValid;
      end
      `USR_LEVEL_ADDR: begin
        next_rdata[LW-1:0] = fifoLevel;
      end
      default: begin
        next_rdata = `USR_READ_ZERO;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= `USR_READ_ZERO;
    end else if (busReq.rd) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= `USR_READ_ZERO;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n || !master_clear_n);

  sequence stepIn(usr_pkg::usr_mode_t m);
    stepEn && (mode == m);
  endsequence

  sequence noStep;
    !stepEn;
  endsequence

  // a rise that meets a full capture fifo is parked, then replayed once room returns
  sequence deferStep;
    wantStep && captureEn && !fifoInReady;
  endsequence

  sequence roomBack;
    pending && fifoInReady;
  endsequence

  load_capture_a: assert property (
    stepIn(usr_pkg::MODE_LOAD) |=> state == $past(sharedParallelPinsIn))
    else $error("load did not capture the parallel pins");

  shift_right_a: assert property (
    stepIn(usr_pkg::MODE_SHIFT_RIGHT) |=>
      state == {$past(state[WIDTH-2:0]), $past(right_shift_serial_in)})
    else $error("shift right result wrong");

  shift_left_a: assert property (
    stepIn(usr_pkg::MODE_SHIFT_LEFT) |=>
      state == {$past(left_shift_serial_in), $past(state[WIDTH-1:1])})
    else $error("shift left result wrong");

  hold_keep_a: assert property (
    stepIn(usr_pkg::MODE_HOLD) |=> $stable(state))
    else $error("hold changed the register");

  edge_only_a: assert property (
    noStep |=> $stable(state))
    else $error("register changed without a clock edge");

  rise_to_step_a: assert property (
    (shift_clock && !clockPrev && !captureEn) |-> stepEn)
    else $error("rising shift clock gave no step");

  enable_float_a: assert property (
    (pin_drive_enable_a_n || pin_drive_enable_b_n) |-> sharedParallelPinsOe == '0)
    else $error("pins driven while an enable is high");

  load_float_a: assert property (
    (mode_select_high && mode_select_low) |-> sharedParallelPinsOe == '0)
    else $error("pins driven during load mode");

  pin_drive_a: assert property (
    (!pin_drive_enable_a_n && !pin_drive_enable_b_n && !(mode_select_high && mode_select_low))
      |-> (sharedParallelPinsOe == '1) && (sharedParallelPinsOut == state))
    else $error("enabled pins do not show the register");

  float_runs_a: assert property (
    (pin_drive_enable_a_n and stepIn(usr_pkg::MODE_SHIFT_RIGHT)) |=>
      state[0] == $past(right_shift_serial_in))
    else $error("register stalled while pins float");

  serial_out_a: assert property (
    ##1 (serial_out_first_bit == state[0]) && (serial_out_last_bit == state[WIDTH-1]))
    else $error("serial outputs do not follow end bits");

  clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !master_clear_n |-> state == '0)
    else $error("master clear did not zero the register");

  decode_map_a: assert property (
    mode == usr_pkg::usr_mode_t'({mode_select_high, mode_select_low}))
    else $error("mode selects decoded wrongly");

  oe_uniform_a: assert property (
    (sharedParallelPinsOe == '0) || (sharedParallelPinsOe == '1))
    else $error("pin drive enables differ between bits");

  chain_right_a: assert property (
    stepIn(usr_pkg::MODE_SHIFT_RIGHT) |=> serial_out_last_bit == $past(state[WIDTH-2]))
    else $error("last serial output missed the right shift");

  chain_left_a: assert property (
    stepIn(usr_pkg::MODE_SHIFT_LEFT) |=> serial_out_first_bit == $past(state[1]))
    else $error("first serial output missed the left shift");

  defer_full_a: assert property (
    deferStep |=> pending && $stable(state))
    else $error("step taken into a full capture fifo");

  defer_resume_a: assert property (
    roomBack |-> stepEn)
    else $error("deferred step not taken once room returned");

  capture_push_a: assert property (
    (stepEn && captureEn) |=> capValid)
    else $error("snapshot after a step was not offered to the fifo");

  rdata_idle_a: assert property (
    !regRd |=> regRdata == '0)
    else $error("read data present without a read strobe");

endmodule

/* File: usr_top_tb.sv */
// self-checking bench for the universal shift register top
module usr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, master_clear_n = 1'b1, shift_clock = 1'b0;
  logic [1:0] sel = 2'b00;
  logic rIn = 1'b0, lIn = 1'b0, enA = 1'b0, enB = 1'b0, drvEn = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [7:0] drvData = 8'h00, regAddr = 8'h00, pOut, pOe, pins;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, rv;
  logic qFirst, qLast;
  int err_total = 0;
  int checked = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  usr_top usr_top_inst (
    .clk(clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
    .shift_clock(shift_clock), .mode_select_high(sel[1]), .mode_select_low(sel[0]),
    .right_shift_serial_in(rIn), .left_shift_serial_in(lIn),
    .pin_drive_enable_a_n(enA), .pin_drive_enable_b_n(enB),
    .sharedParallelPinsIn(pins), .sharedParallelPinsOut(pOut), .sharedParallelPinsOe(pOe),
    .serial_out_first_bit(qFirst), .serial_out_last_bit(qLast),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata)
  );

  usr_bus_model usr_bus_model_inst (
    .clk(clk), .devOut(pOut), .devOe(pOe), .drvEn(drvEn), .drvData(drvData),
    .pinLevel(pins)
  );

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one rise of the device clock pin, then settle
  task automatic step(input logic [1:0] m);
    @(posedge clk);
    sel <= m;
    shift_clock <= 1'b1;
    @(posedge clk);
    shift_clock <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask

  task automatic t_load;
    @(posedge clk);
    drvEn <= 1'b1;
    drvData <= 8'ha5;
    step(2'b11);
    chk(pOe, 8'h00);
    chk(pOut, 8'ha5);
    chk({qLast, qFirst}, 2'b11);
  endtask

  task automatic t_shifts;
    @(posedge clk);
    rIn <= 1'b1;
    step(2'b01);
    chk(pOut, 8'h4b);
    chk(pOe, 8'hff);
    chk(qFirst, 1'b1);
    step(2'b10);
    chk(pOut, 8'h25);
    chk({qLast, qFirst}, 2'b01);
  endtask

  // inputs wander without a clock rise, then a hold step
  task automatic t_hold;
    @(posedge clk);
    sel <= 2'b01;
    rIn <= 1'b0;
    lIn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(pOut, 8'h25);
    step(2'b00);
    chk(pOut, 8'h25);
  endtask

  task automatic t_float;
    @(posedge clk);
    enA <= 1'b1;
    #1 chk(pOe, 8'h00);
    step(2'b01);
    rd(8'h04);
    chk(rv[7:0], 8'h4a);
    @(posedge clk);
    enA <= 1'b0;
    enB <= 1'b1;
    #1 chk(pOe, 8'h00);
    @(posedge clk);
    enB <= 1'b0;
    #1 chk(pOe, 8'hff);
    chk(pOut, 8'h4a);
  endtask

  task automatic t_clear;
    @(posedge clk);
    rIn <= 1'b1;
    master_clear_n <= 1'b0;
    step(2'b01);
    chk({pOut, qLast, qFirst}, 10'h000);
    @(posedge clk);
    master_clear_n <= 1'b1;
    step(2'b01);
    chk(pOut, 8'h01);
  endtask

  // capture fifo filled past full, then drained to empty
  task automatic t_fifo;
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 33; i++) begin
      step(2'b00);
    end
    rd(8'h0c);
    chk(rv, 32'h0000_0020);
    rd(8'h04);
    chk(rv[13:11], 3'b110);
    for (int i = 0; i < 33; i++) begin
      rd(8'h08);
      chk(rv, 32'h0000_0101);
    end
    rd(8'h08);
    chk(rv[8], 1'b0);
    rd(8'h04);
    chk(rv[13:11], 3'b001);
    wr(8'h10, 32'h0000_00ff);
    rd(8'h10);
    chk(rv, 32'h0000_0000);
    rd(8'h00);
    chk(rv, 32'h0000_0001);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00);
    chk(rv, 32'h0000_0000);
    t_load;
    t_shifts;
    t_hold;
    t_float;
    t_clear;
    t_fifo;
    print_verdict;
  end

  // the run needs well under a thousand cycles
  initial begin
    #50000;
    err_total++;
    print_verdict;
  end
endmodule
